// file: ccts_electrode.sv
// electrode with pull-up resistor, as seen from the sensor pin
`timescale 1ns/1ps
module ccts_electrode
(
  // clock
  input wire logic clk_sys,
  // pin drive from the sensor
  input wire logic elec_out,
  input wire logic elec_oe,
  // charge time in clocks
  input wire logic [15:0] charge_cyc,
  // pin level seen by the sensor
  output logic elec_in
);
  int rel_cnt = 0;
  // released from high stays charged, so skipping discharge reads 1
  always @(posedge clk_sys)
    rel_cnt <= elec_oe ? (elec_out ? 65535 : 0) : rel_cnt + 1;
  // below the trip point the released pin reads low
  assign elec_in = elec_oe ? elec_out : (rel_cnt >= int'(charge_cyc));
endmodule

// file: ccts_pin_sync.sv
// two-flop synchroniser for the electrode input
`timescale 1ns/1ps
module ccts_pin_sync
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // pin in, synchronised out
  input wire logic pin_in,
  output logic pin_sync
);

  logic s1_r;
  logic s2_r;
  logic s1_nxt;
  logic s2_nxt;

  // only the second stage is read outside
  always_comb
  begin
    s1_nxt = pin_in;
    s2_nxt = s1_r;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end
    else
    begin
      s1_r <= s1_nxt; // R19
      s2_r <= s2_nxt;
    end
  end

  assign pin_sync = s2_r;

endmodule

// file: ccts_pkg.sv
// package of constants and types for the charge-time sensor
package ccts_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int SYS_CLK_HZ = 10_000_000;
  localparam int CNT_CLK_HZ = 2_500_000;
  localparam int CNT_RES_NS = 400;
  // system clocks per counter tick
  localparam int TICK_DIV = SYS_CLK_HZ / CNT_CLK_HZ;
  localparam int DIV_W = 2;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = 2'h0;
  // discharge time in system clocks
  localparam int DISCH_NS = 1000;
  localparam int DISCH_CYC = (DISCH_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;

  // ------------------------------------------------------------------
  // widths and values
  // ------------------------------------------------------------------
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
  localparam int NSMP_W = 8;
  localparam logic [NSMP_W-1:0] NSMP_ZERO = 8'h00;
  localparam logic [NSMP_W-1:0] NSMP_ONE = 8'h01;
  localparam int DCH_W = 8;
  localparam logic [DCH_W-1:0] DCH_LAST = DCH_W'(DISCH_CYC - 1);
  localparam logic [DCH_W-1:0] DCH_ZERO = 8'h00;
  // noise filter: largest accepted jump from previous sample
  localparam logic [CNT_W-1:0] NOISE_LIM_DEF = 8'h20;

  // ------------------------------------------------------------------
  // commands and status
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    CCTS_CMD_NONE = 2'h0,
    CCTS_CMD_RESTART = 2'h1,
    CCTS_CMD_PROCESS = 2'h2
  } ccts_cmd_e;

  typedef enum logic [1:0] {
    CCTS_ST_OK = 2'h0,
    CCTS_ST_BUSY = 2'h1,
    CCTS_ST_TIMEOUT = 2'h2
  } ccts_status_e;

endpackage

// file: ccts_sensor.sv
// charge-time capacitive electrode sensor, top level
// Operation
// R1 - idle: electrode pin driven high as output
// R2 - measurement start: drive pin low to discharge electrode
// R3 - after discharge release pin to input so pull-up charges it
// R4 - counter accumulates ticks while electrode charges until pin high
// R5 - pin high: stop counter, latch count, discharge again
// R6 - restart command: no action, report in-progress status
// R7 - process command: status ok, clear counter, clear sample flag
// R8 - after sample, timeout flag set: report timeout, remaining to zero
// R9 - good sample: store count, remaining samples minus one
// R10 - noise filter enabled: valid samples pass it before acceptance
// R11 - remaining zero ends sequence with status, else sample again
// R12 - start timer first, then release pin to input
// R13 - timeout before high: pulse interrupt, set flag, stop counter
// R14 - pin high in time: leave wait, stop counter, no timeout flag
// R15 - each low-level sample outputs raw timer count
// R16 - counter 8 bits wide, at most 255 counts
// R17 - counter tick 2.5 MHz from 10 MHz clock, 400 ns
// R18 - count at the highest allowed rate for finest step
// R19 - synchronise pin input; counter overflow means timeout
`timescale 1ns/1ps
module ccts_sensor
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // command port from key detector
  input wire logic [1:0] cmd,
  input wire logic cmd_valid,
  input wire logic [ccts_pkg::NSMP_W-1:0] num_samples,
  input wire logic noise_filt_en,
  input wire logic [ccts_pkg::CNT_W-1:0] noise_limit,
  // status back
  output logic [1:0] status,
  output logic status_valid,
  output logic busy,
  // sample results
  output logic [ccts_pkg::CNT_W-1:0] raw_count,
  output logic raw_valid,
  output logic [ccts_pkg::CNT_W-1:0] sample,
  output logic sample_valid,
  output logic timeout_irq,
  output logic sample_flag,
  // electrode pin
  input wire logic elec_in,
  output logic elec_out,
  output logic elec_oe
);

  // ------------------------------------------------------------------
  // state and storage
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE,
    S_DISCH,
    S_TSTART,
    S_CHARGE,
    S_EVAL
  } ccts_state_e;

  ccts_state_e st_r, st_nxt;
  logic [ccts_pkg::DCH_W-1:0] dch_r, dch_nxt;
  logic [ccts_pkg::NSMP_W-1:0] rem_r, rem_nxt;
  logic [1:0] status_r, status_nxt;
  logic status_v_r, status_v_nxt;
  logic [ccts_pkg::CNT_W-1:0] raw_r, raw_nxt;
  logic raw_v_r, raw_v_nxt;
  logic [ccts_pkg::CNT_W-1:0] smp_r, smp_nxt;
  logic smp_v_r, smp_v_nxt;
  logic have_prev_r, have_prev_nxt;
  logic tof_r, tof_nxt;
  logic irq_r, irq_nxt;
  logic flag_r, flag_nxt;
  logic pin_hi;

  ccts_timer_if tif ();

  // ------------------------------------------------------------------
  // leaf modules
  // ------------------------------------------------------------------
  ccts_timer u_timer
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .t(tif.tmr)
  );

  ccts_pin_sync u_sync
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_in(elec_in),
    .pin_sync(pin_hi)
  );

  // absolute difference, used by the noise filter
  function automatic logic [ccts_pkg::CNT_W-1:0] abs_diff
  (
    input logic [ccts_pkg::CNT_W-1:0] a,
    input logic [ccts_pkg::CNT_W-1:0] b
  );
    abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction

  // ------------------------------------------------------------------
  // timer steering from state
  // ------------------------------------------------------------------
  // clear during discharge; run from timer-start through charge
  always_comb
  begin
    tif.clear = (st_r == S_DISCH); // R7
    tif.run = (st_r == S_TSTART) || (st_r == S_CHARGE); // R12
  end

  // ------------------------------------------------------------------
  // sequencer next state
  // ------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    dch_nxt = dch_r;
    rem_nxt = rem_r;
    status_nxt = status_r;
    status_v_nxt = 1'b0;
    raw_nxt = raw_r;
    raw_v_nxt = 1'b0;
    smp_nxt = smp_r;
    smp_v_nxt = 1'b0;
    have_prev_nxt = have_prev_r;
    tof_nxt = tof_r;
    irq_nxt = 1'b0;
    flag_nxt = flag_r;
    unique case (st_r)
      S_IDLE:
      begin
        if (cmd_valid && cmd == ccts_pkg::CCTS_CMD_RESTART)
        begin
          // nothing to do for this method, answer at once
          status_nxt = ccts_pkg::CCTS_ST_BUSY; // R6
          status_v_nxt = 1'b1;
        end
        else if (cmd_valid && cmd == ccts_pkg::CCTS_CMD_PROCESS)
        begin
          status_nxt = ccts_pkg::CCTS_ST_OK; // R7
          flag_nxt = 1'b0; // R7
          tof_nxt = 1'b0;
          have_prev_nxt = 1'b0;
          // zero samples asked: finish right away
          if (num_samples == ccts_pkg::NSMP_ZERO)
            status_v_nxt = 1'b1;
          else
          begin
            rem_nxt = num_samples;
            dch_nxt = ccts_pkg::DCH_ZERO;
            st_nxt = S_DISCH; // R2
          end
        end
      end
      S_DISCH:
      begin
        if (dch_r == ccts_pkg::DCH_LAST)
          st_nxt = S_TSTART;
        else
          dch_nxt = dch_r + 1'b1;
      end
      S_TSTART:
        st_nxt = S_CHARGE; // R12 R3
      S_CHARGE:
      begin
        if (pin_hi)
          st_nxt = S_EVAL; // R14
        else if (tif.overflow)
        begin
          // a late edge beats overflow: the count is saturated anyway
          irq_nxt = 1'b1; // R13
          tof_nxt = 1'b1; // R13
          st_nxt = S_EVAL;
        end
      end
      S_EVAL:
      begin
        // counter already stopped since run drops here
        raw_nxt = tif.count; // R15 R5
        raw_v_nxt = 1'b1;
        flag_nxt = 1'b1;
        dch_nxt = ccts_pkg::DCH_ZERO;
        if (tof_r)
        begin
          status_nxt = ccts_pkg::CCTS_ST_TIMEOUT; // R8
          rem_nxt = ccts_pkg::NSMP_ZERO; // R8
        end
        else
        begin
          // filter rejects big jumps; rejected samples do not count
          if (!noise_filt_en || !have_prev_r
              || abs_diff(tif.count, smp_r) <= noise_limit) // R10
          begin
            smp_nxt = tif.count; // R9
            smp_v_nxt = 1'b1;
            have_prev_nxt = 1'b1;
            rem_nxt = rem_r - ccts_pkg::NSMP_ONE; // R9
          end
        end
        if (tof_r || (rem_nxt == ccts_pkg::NSMP_ZERO))
        begin
          status_v_nxt = 1'b1; // R11
          st_nxt = S_IDLE; // R1
        end
        else
          st_nxt = S_DISCH; // R11 R5
      end
      default:
        st_nxt = S_IDLE;
    endcase
  end

  // ------------------------------------------------------------------
  // sequencer registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st_r <= S_IDLE;
      dch_r <= ccts_pkg::DCH_ZERO;
      rem_r <= ccts_pkg::NSMP_ZERO;
      status_r <= ccts_pkg::CCTS_ST_OK;
      status_v_r <= 1'b0;
      raw_r <= ccts_pkg::CNT_ZERO;
      raw_v_r <= 1'b0;
      smp_r <= ccts_pkg::CNT_ZERO;
      smp_v_r <= 1'b0;
      have_prev_r <= 1'b0;
      tof_r <= 1'b0;
      irq_r <= 1'b0;
      flag_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      dch_r <= dch_nxt;
      rem_r <= rem_nxt;
      status_r <= status_nxt;
      status_v_r <= status_v_nxt;
      raw_r <= raw_nxt;
      raw_v_r <= raw_v_nxt;
      smp_r <= smp_nxt;
      smp_v_r <= smp_v_nxt;
      have_prev_r <= have_prev_nxt;
      tof_r <= tof_nxt;
      irq_r <= irq_nxt;
      flag_r <= flag_nxt;
    end
  end

  // ------------------------------------------------------------------
  // pin drive and outputs
  // ------------------------------------------------------------------
  // driven high when idle, low in discharge, released while charging
  always_comb
  begin
    // timer starts one cycle before the pin lets go, so no edge is missed
    elec_oe = !(st_r == S_CHARGE); // R3 R12
    elec_out = (st_r == S_IDLE); // R1 R2
  end

  assign status = status_r;
  assign status_valid = status_v_r;
  assign busy = (st_r != S_IDLE);
  assign raw_count = raw_r;
  assign raw_valid = raw_v_r;
  assign sample = smp_r;
  assign sample_valid = smp_v_r;
  assign timeout_irq = irq_r;
  assign sample_flag = flag_r;

endmodule

// file: ccts_sensor_checker.sv
// assertion checker for the charge-time sensor top
`timescale 1ns/1ps
module ccts_sensor_checker
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // command side
  input wire logic [1:0] cmd,
  input wire logic cmd_valid,
  input wire logic [7:0] num_samples,
  // results
  input wire logic [1:0] status,
  input wire logic status_valid,
  input wire logic busy,
  input wire logic [7:0] raw_count,
  input wire logic raw_valid,
  input wire logic timeout_irq,
  input wire logic sample_flag,
  // electrode pin
  input wire logic elec_in,
  input wire logic elec_out,
  input wire logic elec_oe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic [10:0] rel_r;
  logic [10:0] rel_nxt;
  logic proc_go;
  logic raw_seen_r;
  logic raw_seen_nxt;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // released-pin run length; a wait that never ends shows up here
  always_comb rel_nxt = elec_oe ? 11'h000 : rel_r + 11'h001;
  always_ff @(posedge clk_sys) rel_r <= !rst_n ? 11'h000 : rel_nxt;
  assign proc_go = cmd_valid && cmd == 2'h2 && !busy;
  // a sample already reported in the running sequence
  always_comb raw_seen_nxt = busy && (raw_seen_r || raw_valid);
  always_ff @(posedge clk_sys) raw_seen_r <= !rst_n ? 1'b0 : raw_seen_nxt;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  idle_pin_a: assert property (!busy |-> elec_oe && elec_out)
    else $error("idle pin not high");
  disch_start_a: assert property (proc_go && num_samples != 8'h00
    |=> busy && elec_oe && !elec_out) else $error("no discharge");
  disch_hold_a: assert property ($fell(elec_out) |->
    (elec_oe && !elec_out)[*8]) else $error("discharge too short");
  release_order_a: assert property ($fell(elec_oe) |->
    !$past(elec_out) && busy) else $error("released undischarged");
  pin_stop_a: assert property ($rose(elec_in) && !elec_oe
    |-> ##[2:8] raw_valid) else $error("pin high not seen");
  restart_busy_a: assert property (cmd_valid && cmd == 2'h1 && !busy
    |-> ##[1:2] (status_valid && status == 2'h1)) else $error("restart");
  proc_preset_a: assert property (proc_go && num_samples == 8'h00
    |-> ##[1:2] (status_valid && status == 2'h0)) else $error("preset");
  flag_clear_a: assert property (proc_go |=> !sample_flag)
    else $error("flag not cleared");
  timeout_end_a: assert property (timeout_irq |-> ##[1:3]
    (status_valid && status == 2'h2 && raw_count == 8'hFF))
    else $error("timeout end");
  wait_bound_a: assert property (rel_r <= 11'h424)
    else $error("wait not bounded");
  // ----------------------------------------
  // covers
  // ----------------------------------------
  restart_c: cover property (status_valid && status == 2'h1);
  timeout_c: cover property (timeout_irq);
  multi_c: cover property (raw_valid && raw_seen_r);
endmodule

bind ccts_sensor ccts_sensor_checker chk (.clk_sys, .rst_n, .cmd,
  .cmd_valid, .num_samples, .status, .status_valid, .busy, .raw_count,
  .raw_valid, .timeout_irq, .sample_flag, .elec_in, .elec_out, .elec_oe);

// file: ccts_timer.sv
// prescaled 8-bit charge-time counter
`timescale 1ns/1ps
module ccts_timer
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control and count
  ccts_timer_if.tmr t
);

  logic [ccts_pkg::DIV_W-1:0] div_r;
  logic [ccts_pkg::DIV_W-1:0] div_nxt;
  logic [ccts_pkg::CNT_W-1:0] cnt_r;
  logic [ccts_pkg::CNT_W-1:0] cnt_nxt;
  logic ovf_r;
  logic ovf_nxt;

  // divide 10 MHz down to a 2.5 MHz tick and count ticks
  always_comb
  begin
    div_nxt = div_r;
    cnt_nxt = cnt_r;
    ovf_nxt = ovf_r;
    if (t.clear)
    begin
      div_nxt = ccts_pkg::DIV_ZERO;
      cnt_nxt = ccts_pkg::CNT_ZERO;
      ovf_nxt = 1'b0;
    end
    else if (t.run && !ovf_r)
    begin
      if (div_r == ccts_pkg::DIV_LAST) // R17 R18
      begin
        div_nxt = ccts_pkg::DIV_ZERO;
        // saturate at 255; a further tick at the top is the timeout
        if (cnt_r == ccts_pkg::CNT_MAX) // R16 R19
          ovf_nxt = 1'b1;
        else
          cnt_nxt = cnt_r + 1'b1; // R4
      end
      else
        div_nxt = div_r + 1'b1;
    end
  end

  // registers only
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      div_r <= ccts_pkg::DIV_ZERO;
      cnt_r <= ccts_pkg::CNT_ZERO;
      ovf_r <= 1'b0;
    end
    else
    begin
      div_r <= div_nxt;
      cnt_r <= cnt_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  assign t.count = cnt_r;
  assign t.overflow = ovf_r;

endmodule

// file: ccts_timer_if.sv
// interface between sequencer and low-level timer
`timescale 1ns/1ps
interface ccts_timer_if;
  logic clear;
  logic run;
  logic [ccts_pkg::CNT_W-1:0] count;
  logic overflow;

  modport ctrl (output clear, output run, input count, input overflow);
  modport tmr (input clear, input run, output count, output overflow);
endinterface

// file: tb_cap_charge_time_sensor.sv
// self-checking bench for the charge-time sensor
`timescale 1ns/1ps
module tb_cap_charge_time_sensor;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] cmd = 2'h0;
  logic cmd_valid = 1'b0;
  logic [7:0] num_samples = 8'h00;
  logic noise_filt_en = 1'b0;
  logic [7:0] noise_limit = 8'h04;
  logic [15:0] charge_cyc = 16'h0064;
  logic [1:0] status;
  logic status_valid, busy, raw_valid, sample_valid, timeout_irq;
  logic sample_flag, elec_in, elec_out, elec_oe;
  logic [7:0] raw_count, sample;
  int error_cnt = 0;
  int check_count = 0;
  int exp_q[$];

  // 10 MHz system clock
  always #50 clk_sys = ~clk_sys;

  ccts_sensor dut (.clk_sys, .rst_n, .cmd, .cmd_valid, .num_samples,
    .noise_filt_en, .noise_limit, .status, .status_valid, .busy,
    .raw_count, .raw_valid, .sample, .sample_valid, .timeout_irq,
    .sample_flag, .elec_in, .elec_out, .elec_oe);
  ccts_electrode elec (.clk_sys, .elec_out, .elec_oe, .charge_cyc,
    .elec_in);

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input bit ok, input string msg);
    check_count++;
    if (!ok)
    begin
      error_cnt++;
      $display("mismatch at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic complete_run;
    if (error_cnt == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one-cycle strobe, entered and left at a falling edge
  task automatic send(input logic [1:0] c, input logic [7:0] n);
    cmd = c;
    num_samples = n;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
  endtask

  // process sequence; queue holds the charge-time counts to expect
  task automatic run_proc(input int n, input int ch, input bit poke);
    int w;
    int to_cnt;
    int ok_cnt;
    int e;
    bit to;
    to = ch > 1100;
    to_cnt = 0;
    ok_cnt = 0;
    charge_cyc = 16'(ch);
    exp_q.delete();
    for (w = 0; w < (to ? 1 : n); w++)
      exp_q.push_back(to ? 255 : ch / 4);
    send(2'h2, 8'(n));
    check(sample_flag === 1'b0, "flag");
    // a restart while busy must be dropped
    if (poke)
    begin
      @(negedge clk_sys);
      send(2'h1, 8'h00);
    end
    for (w = 0; w < 20000; w++)
    begin
      if (raw_valid === 1'b1)
      begin
        check(exp_q.size() > 0, "extra sample");
        e = exp_q.size() > 0 ? exp_q.pop_front() : 0;
        check(to ? raw_count === 8'hFF :
          raw_count inside {[8'(e - 1):8'(e + 2)]}, "raw count");
        if (sample_valid === 1'b1)
          check(sample inside {[8'(e - 1):8'(e + 2)]}, "sample");
      end
      to_cnt += (timeout_irq === 1'b1);
      ok_cnt += (sample_valid === 1'b1);
      if (status_valid === 1'b1)
        break;
      @(negedge clk_sys);
    end
    if (w == 20000)
    begin
      check(1'b0, "no status");
      complete_run;
    end
    check(status === (to ? 2'h2 : 2'h0), "status");
    check(exp_q.size() == 0 && ok_cnt == (to ? 0 : n), "count");
    check(to_cnt == int'(to), "irq");
    check(sample_flag === (n > 0), "flag set");
    @(negedge clk_sys);
    check(busy === 1'b0 && elec_oe === 1'b1 && elec_out === 1'b1,
      "idle");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    int i;
    int k;
    int n_ok;
    void'($urandom(71216));
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    check(busy === 1'b0 && elec_oe === 1'b1 && elec_out === 1'b1,
      "reset");
    // codes 0 and 3 are ignored, restart only answers in-progress
    for (i = 0; i < 4; i++)
    begin
      if (i == 2)
        continue;
      send(2'(i), 8'h03);
      check(status_valid === (i == 1) && raw_valid === 1'b0, "ans");
      check(busy === 1'b0 && (i != 1 || status === 2'h1), "rst");
      @(negedge clk_sys);
    end
    run_proc(0, 100, 1'b0);
    for (i = 0; i < 4; i++)
    begin
      noise_filt_en = 1'($urandom);
      run_proc(1 + $urandom % 4, 40 + $urandom % 560, 1'(i == 2));
    end
    run_proc(2, 1000, 1'b0);
    run_proc(3, 2000, 1'b0);
    run_proc(1, 60, 1'b0);
    // a jump past the limit is dropped and the sample taken again
    noise_filt_en = 1'b1;
    noise_limit = 8'h04;
    charge_cyc = 16'h0064;
    k = 0;
    n_ok = 0;
    send(2'h2, 8'h02);
    for (i = 0; i < 20000; i++)
    begin
      n_ok += (sample_valid === 1'b1);
      k += (raw_valid === 1'b1);
      charge_cyc = (k == 1) ? 16'h012C : 16'h0064;
      if (status_valid === 1'b1)
        break;
      @(negedge clk_sys);
    end
    check(i < 20000 && k == 3 && n_ok == 2, "filter count");
    check(sample inside {[8'h18:8'h1B]}, "filter sample");
    complete_run;
  end
endmodule
